// file: hw/rgc_defines.svh
// Constants for the refresh granularity link: mode register fields,
// refresh codes, timing figures and the register map of the controller.
// Assumes a 100 MHz system clock on both ends.
`ifndef RGC_DEFINES_SVH
`define RGC_DEFINES_SVH

// ==========================================================
// Clock and link
`define RGC_CLK_NS        10
`define RGC_CK_DIV        4
`define RGC_CK_FALL_PH    2'h1

// ==========================================================
// Mode register numbers and fields
`define RGC_MR_RATE       3'h3
`define RGC_MR_TCR        3'h4
`define RGC_RATE_LSB      6
`define RGC_RATE_MSB      8
`define RGC_TCR_EN_BIT    3
`define RGC_TCR_EXT_BIT   2
`define RGC_RATE_RESET    3'h0

// ==========================================================
// Timing figures (ns) and cycle counts
`define RGC_TREFI_BASE_NS 7800
`define RGC_TREFI_EXT_NS  3900
`define RGC_TRFC1_NS      350
`define RGC_TRFC2_NS      260
`define RGC_TRFC4_NS      160
`define RGC_TREFI_BASE_CYC (`RGC_TREFI_BASE_NS / `RGC_CLK_NS)
`define RGC_TREFI_EXT_CYC  (`RGC_TREFI_EXT_NS / `RGC_CLK_NS)
`define RGC_TRFC1_CYC     ((`RGC_TRFC1_NS + `RGC_CLK_NS - 1) / `RGC_CLK_NS)
`define RGC_TRFC2_CYC     ((`RGC_TRFC2_NS + `RGC_CLK_NS - 1) / `RGC_CLK_NS)
`define RGC_TRFC4_CYC     ((`RGC_TRFC4_NS + `RGC_CLK_NS - 1) / `RGC_CLK_NS)

// ==========================================================
// Controller register map
`define RGC_REG_CTRL      8'h00
`define RGC_REG_OTF       8'h04
`define RGC_REG_STATUS    8'h08
`define RGC_CTRL_RUN_BIT  5
`define RGC_CTRL_EXT_BIT  4
`define RGC_CTRL_TCR_BIT  3

`endif

// file: hw/rgc_pkg.sv
// Types shared by both ends of the refresh granularity link.
// Assumes rgc_defines.svh for all numeric constants.
package rgc_pkg;

  typedef enum logic [2:0] {
    RGC_FIX1X   = 3'b000,
    RGC_FIX2X   = 3'b001,
    RGC_FIX4X   = 3'b010,
    RGC_RSV3    = 3'b011,
    RGC_RSV4    = 3'b100,
    RGC_OTF12   = 3'b101,
    RGC_OTF14   = 3'b110,
    RGC_RSV7    = 3'b111
  } rgc_rate_t;

  typedef enum logic [1:0] {
    RGC_G1X = 2'b00,
    RGC_G2X = 2'b01,
    RGC_G4X = 2'b10
  } rgc_gran_t;

  typedef struct packed {
    logic        ck;
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        bg1;
    logic        bg0;
    logic [1:0]  ba;
    logic [13:0] addr;
  } rgc_link_t;

  typedef enum logic [2:0] {
    RGC_IDLE = 3'b000,
    RGC_MRS3 = 3'b001,
    RGC_MRS4 = 3'b010,
    RGC_RUN  = 3'b011,
    RGC_REFW = 3'b100
  } rgc_cstate_t;

endpackage

// file: hw/rgc_link_if.sv
// Command link between the memory controller end and the DRAM end.
// Assumes the controller drives every signal; the DRAM only listens.
`timescale 1ns/1ps
interface rgc_link_if;
  logic        ck;
  logic        cs_n;
  logic        act_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        bg1;
  logic        bg0;
  logic [1:0]  ba;
  logic [13:0] addr;

  modport ctrl (output ck, cs_n, act_n, ras_n, cas_n, we_n, bg1, bg0, ba, addr);
  modport dram (input  ck, cs_n, act_n, ras_n, cas_n, we_n, bg1, bg0, ba, addr);
endinterface

// file: hw/rgc_dram.sv
// DRAM end: decodes mode register writes and refreshes, tracks granularity,
// flags commands inside the refresh cycle time and gears down internal refresh under extended TCR while cool.
// Assumes link signals and TEMP_HOT are asynchronous to CLK; ck is slow
// enough (4 CLK per period or more) to be edge-detected after sync.
`timescale 1ns/1ps
`include "rgc_defines.svh"

module rgc_dram (
  // Clock and reset
  input  wire logic           CLK,
  input  wire logic           SRST,
  // Link from the controller
  rgc_link_if.dram            link,
  // Case temperature above 85C
  input  wire logic           TEMP_HOT,
  // Status
  output logic [2:0]          RATE_MODE,
  output logic                TCR_ON,
  output logic                TCR_EXT,
  output logic [1:0]          REF_GRAN,
  output logic                INT_REFRESH,
  output logic                RFC_BUSY,
  output logic                ERR_TIMING,
  output logic                ERR_MODE
);

  typedef struct packed {
    rgc_pkg::rgc_link_t s1;
    rgc_pkg::rgc_link_t s2;
    logic               ck_d;
    logic               t1;
    logic               t2;
    rgc_pkg::rgc_rate_t rate;
    logic               tcr_en;
    logic               tcr_ext;
    rgc_pkg::rgc_gran_t gran;
    logic [5:0]         rfc_cnt;
    logic               rfc_busy;
    logic               skip_ph;
    logic               int_ref;
    logic               err_timing;
    logic               err_mode;
  } rgc_dstate_t;

  rgc_dstate_t st;
  rgc_dstate_t next_st;

  rgc_pkg::rgc_link_t lk;
  logic               ck_rise;
  logic               is_ref;
  logic               is_mrs;
  logic               is_cmd;
  logic [2:0]         mr_num;
  rgc_pkg::rgc_gran_t ref_gran;
  logic [5:0]         rfc_load;

  // ==========================================================
  // Command decode on the synchronised link
  always_comb begin
    lk      = st.s2;
    ck_rise = lk.ck & ~st.ck_d;
    is_cmd  = ck_rise & ~lk.cs_n;
    is_ref  = is_cmd & lk.act_n & ~lk.ras_n & ~lk.cas_n & lk.we_n;
    is_mrs  = is_cmd & lk.act_n & ~lk.ras_n & ~lk.cas_n & ~lk.we_n;
    mr_num  = {lk.bg1, lk.ba};
    unique case (st.rate)
      rgc_pkg::RGC_FIX2X: ref_gran = rgc_pkg::RGC_G2X;
      rgc_pkg::RGC_FIX4X: ref_gran = rgc_pkg::RGC_G4X;
      rgc_pkg::RGC_OTF12: ref_gran = lk.bg0 ? rgc_pkg::RGC_G2X : rgc_pkg::RGC_G1X;
      rgc_pkg::RGC_OTF14: ref_gran = lk.bg0 ? rgc_pkg::RGC_G4X : rgc_pkg::RGC_G1X;
      default:            ref_gran = rgc_pkg::RGC_G1X;
    endcase
    unique case (ref_gran)
      rgc_pkg::RGC_G2X: rfc_load = 6'(`RGC_TRFC2_CYC - 1);
      rgc_pkg::RGC_G4X: rfc_load = 6'(`RGC_TRFC4_CYC - 1);
      default:          rfc_load = 6'(`RGC_TRFC1_CYC - 1);
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st         = st;
    next_st.s1      = {link.ck, link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n,
                       link.bg1, link.bg0, link.ba, link.addr};
    next_st.s2      = st.s1;
    next_st.ck_d    = st.s2.ck;
    next_st.t1      = TEMP_HOT;
    next_st.t2      = st.t1;
    next_st.int_ref = 1'b0;
    if (st.rfc_cnt != 6'h00) begin
      next_st.rfc_cnt = st.rfc_cnt - 6'h01;
    end
    // Any non-deselect command inside tRFC is a violation
    if (is_cmd && st.rfc_cnt != 6'h00) begin
      next_st.err_timing = 1'b1;
    end
    if (is_mrs && mr_num == `RGC_MR_RATE) begin
      next_st.rate = rgc_pkg::rgc_rate_t'(lk.addr[`RGC_RATE_MSB:`RGC_RATE_LSB]);
      unique case (lk.addr[`RGC_RATE_MSB:`RGC_RATE_LSB])
        3'b011, 3'b100, 3'b111: next_st.err_mode = 1'b1;
        default: ;
      endcase
      if (st.tcr_en && lk.addr[`RGC_RATE_MSB:`RGC_RATE_LSB] != `RGC_RATE_RESET) begin
        next_st.err_mode = 1'b1;
      end
    end
    if (is_mrs && mr_num == `RGC_MR_TCR) begin
      next_st.tcr_en  = lk.addr[`RGC_TCR_EN_BIT];
      next_st.tcr_ext = lk.addr[`RGC_TCR_EXT_BIT];
      if (lk.addr[`RGC_TCR_EN_BIT] && st.rate != rgc_pkg::RGC_FIX1X) begin
        next_st.err_mode = 1'b1;
      end
    end
    if (is_ref) begin
      next_st.gran    = ref_gran;
      next_st.rfc_cnt = rfc_load;
      // Extended mode while cool: every other external refresh is skipped
      if (st.tcr_en && st.tcr_ext && !st.t2) begin
        next_st.skip_ph = ~st.skip_ph;
        next_st.int_ref = ~st.skip_ph;
      end else begin
        next_st.skip_ph = 1'b0;
        next_st.int_ref = 1'b1;
      end
    end
    next_st.rfc_busy = next_st.rfc_cnt != 6'h00;
    if (SRST) begin
      next_st            = '0;
      next_st.rate       = rgc_pkg::rgc_rate_t'(`RGC_RATE_RESET);
      next_st.gran       = rgc_pkg::RGC_G1X;
      next_st.s1.cs_n    = 1'b1;
      next_st.s2.cs_n    = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    st <= next_st;
  end

  // ==========================================================
  // Outputs straight from state
  assign RATE_MODE   = st.rate;
  assign TCR_ON      = st.tcr_en;
  assign TCR_EXT     = st.tcr_ext;
  assign REF_GRAN    = st.gran;
  assign INT_REFRESH = st.int_ref;
  assign RFC_BUSY    = st.rfc_busy;
  assign ERR_TIMING  = st.err_timing;
  assign ERR_MODE    = st.err_mode;

endmodule

// file: hw/rgc_ctrl.sv
// Controller end: APB registers, link clock divider, mode register writes
// and a refresh scheduler whose interval follows the chosen granularity.
// Assumes an APB master on CLK and the DRAM end on the link.
`timescale 1ns/1ps
`include "rgc_defines.svh"

// Overview of operation
// - Normal TCR: controller refreshes at base interval
// - Extended TCR: skip refreshes when cool
// - Extended TCR: refresh spacing is 392 CLK (3.92us), 390 CLK rounded up to a slot
// - Mode register write sets refresh timing
// - Rate field decode, reserved codes flagged
// - Program OTF mode before OTF refreshes
// - OTF: BG0 selects 1x or fine refresh
// - Refresh decoded from command pins at edge
// - Reset leaves fixed 1x mode
// - 2x granularity: half base interval
// - 4x granularity: quarter base interval
// - Fixed modes use only their own granularity
// - OTF 1x/2x mixes 1x and 2x
// - OTF 1x/4x never issues 2x
// - Hold off commands for tRFC after refresh
// - TCR enable and temperature mode bits
// - TCR only with fixed 1x mode
module rgc_ctrl (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Link to the DRAM
  rgc_link_if.ctrl         link
);

  typedef struct packed {
    rgc_pkg::rgc_cstate_t fsm;
    logic [1:0]           div;
    rgc_pkg::rgc_link_t   lk;
    rgc_pkg::rgc_rate_t   rate;
    logic                 tcr_en;
    logic                 tcr_ext;
    logic                 run;
    logic                 otf_fine;
    logic                 prog_pend;
    logic                 pre4;
    logic [9:0]           ival;
    logic [5:0]           rfc;
    logic [15:0]          ref_cnt;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } rgc_cst_t;

  rgc_cst_t st;
  rgc_cst_t next_st;

  logic               slot;
  logic               acc;
  rgc_pkg::rgc_gran_t gran;
  logic [9:0]         ival_load;
  logic [5:0]         rfc_load;
  logic [9:0]         base;

  // ==========================================================
  // Granularity of the next refresh and its timing
  always_comb begin
    slot = st.div == `RGC_CK_FALL_PH;
    acc  = PSEL & PENABLE & ~st.pready;
    unique case (st.rate)
      rgc_pkg::RGC_FIX2X: gran = rgc_pkg::RGC_G2X;
      rgc_pkg::RGC_FIX4X: gran = rgc_pkg::RGC_G4X;
      rgc_pkg::RGC_OTF12: gran = st.otf_fine ? rgc_pkg::RGC_G2X : rgc_pkg::RGC_G1X;
      rgc_pkg::RGC_OTF14: gran = st.otf_fine ? rgc_pkg::RGC_G4X : rgc_pkg::RGC_G1X;
      default:            gran = rgc_pkg::RGC_G1X;
    endcase
    base = (st.tcr_en && st.tcr_ext && st.rate == rgc_pkg::RGC_FIX1X)
           ? 10'(`RGC_TREFI_EXT_CYC) : 10'(`RGC_TREFI_BASE_CYC);
    ival_load = base >> gran;
    unique case (gran)
      rgc_pkg::RGC_G2X: rfc_load = 6'(`RGC_TRFC2_CYC);
      rgc_pkg::RGC_G4X: rfc_load = 6'(`RGC_TRFC4_CYC);
      default:          rfc_load = 6'(`RGC_TRFC1_CYC);
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st         = st;
    next_st.div     = st.div + 2'h1;
    next_st.lk.ck   = ~next_st.div[1];
    next_st.pready  = acc;
    next_st.pslverr = 1'b0;
    if (st.ival != 10'h000) begin
      next_st.ival = st.ival - 10'h001;
    end
    if (st.rfc != 6'h00) begin
      next_st.rfc = st.rfc - 6'h01;
    end
    // Registers
    if (acc) begin
      next_st.prdata = 32'h0000_0000;
      unique case (PADDR)
        `RGC_REG_CTRL: begin
          if (PWRITE) begin
            next_st.rate      = rgc_pkg::rgc_rate_t'(PWDATA[2:0]);
            next_st.tcr_en    = PWDATA[`RGC_CTRL_TCR_BIT];
            next_st.tcr_ext   = PWDATA[`RGC_CTRL_EXT_BIT];
            next_st.run       = PWDATA[`RGC_CTRL_RUN_BIT];
            next_st.prog_pend = 1'b1;
          end
          next_st.prdata = {26'h0, st.run, st.tcr_ext, st.tcr_en, st.rate};
        end
        `RGC_REG_OTF: begin
          if (PWRITE) begin
            next_st.otf_fine = PWDATA[0];
          end
          next_st.prdata = {31'h0, st.otf_fine};
        end
        `RGC_REG_STATUS: begin
          next_st.prdata = {st.ref_cnt, 11'h0, st.fsm, st.rfc != 6'h00, st.prog_pend};
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end
    // Link commands change with the falling link clock edge
    if (slot) begin
      next_st.lk.cs_n  = 1'b1;
      next_st.lk.act_n = 1'b1;
      next_st.lk.ras_n = 1'b1;
      next_st.lk.cas_n = 1'b1;
      next_st.lk.we_n  = 1'b1;
      unique case (st.fsm)
        rgc_pkg::RGC_IDLE: begin
          if (st.prog_pend) begin
            next_st.pre4 = 1'b1;
            next_st.fsm  = rgc_pkg::RGC_MRS4;
          end
        end
        rgc_pkg::RGC_MRS3: begin
          // Rate written before any refresh relies on it
          next_st.lk     = {next_st.lk.ck, 5'b01000, 1'b0, 1'b0, 2'h3, 14'h0000};
          next_st.lk.addr[`RGC_RATE_MSB:`RGC_RATE_LSB] = st.rate;
          next_st.prog_pend = acc & PWRITE & (PADDR == `RGC_REG_CTRL);
          next_st.fsm    = rgc_pkg::RGC_MRS4;
        end
        rgc_pkg::RGC_MRS4: begin
          next_st.lk     = {next_st.lk.ck, 5'b01000, 1'b1, 1'b0, 2'h0, 14'h0000};
          if (st.pre4) begin
            // TCR off first, so a rate change never meets TCR still on
            next_st.pre4 = 1'b0;
            next_st.fsm  = rgc_pkg::RGC_MRS3;
          end else begin
            // TCR only allowed together with fixed 1x
            next_st.lk.addr[`RGC_TCR_EN_BIT] = st.tcr_en &&
                                               st.rate == rgc_pkg::RGC_FIX1X;
            next_st.lk.addr[`RGC_TCR_EXT_BIT] = st.tcr_ext;
            next_st.ival   = ival_load;
            next_st.fsm    = st.run ? rgc_pkg::RGC_RUN : rgc_pkg::RGC_IDLE;
          end
        end
        rgc_pkg::RGC_RUN: begin
          if (st.prog_pend) begin
            next_st.pre4 = 1'b1;
            next_st.fsm  = rgc_pkg::RGC_MRS4;
          end else if (!st.run) begin
            next_st.fsm = rgc_pkg::RGC_IDLE;
          end else if (st.ival == 10'h000) begin
            next_st.lk.cs_n  = 1'b0;
            next_st.lk.ras_n = 1'b0;
            next_st.lk.cas_n = 1'b0;
            // BG0 high for any fine refresh, fixed or on-the-fly; the DRAM reads it only in on-the-fly modes
            next_st.lk.bg0   = gran != rgc_pkg::RGC_G1X;
            next_st.ival     = ival_load;
            next_st.rfc      = rfc_load;
            next_st.ref_cnt  = st.ref_cnt + 16'h0001;
            next_st.fsm      = rgc_pkg::RGC_REFW;
          end
        end
        rgc_pkg::RGC_REFW: begin
          if (st.rfc == 6'h00) begin
            next_st.fsm = rgc_pkg::RGC_RUN;
          end
        end
        default: next_st.fsm = rgc_pkg::RGC_IDLE;
      endcase
    end
    if (SRST) begin
      next_st         = '0;
      next_st.lk      = {1'b1, 5'b11111, 1'b0, 1'b0, 2'h0, 14'h0000};
      next_st.rate    = rgc_pkg::rgc_rate_t'(`RGC_RATE_RESET);
    end
  end

  always_ff @(posedge CLK) begin
    st <= next_st;
  end

  // ==========================================================
  // Outputs straight from state
  assign PRDATA     = st.prdata;
  assign PREADY     = st.pready;
  assign PSLVERR    = st.pslverr;
  assign link.ck    = st.lk.ck;
  assign link.cs_n  = st.lk.cs_n;
  assign link.act_n = st.lk.act_n;
  assign link.ras_n = st.lk.ras_n;
  assign link.cas_n = st.lk.cas_n;
  assign link.we_n  = st.lk.we_n;
  assign link.bg1   = st.lk.bg1;
  assign link.bg0   = st.lk.bg0;
  assign link.ba    = st.lk.ba;
  assign link.addr  = st.lk.addr;

endmodule

// file: bench/rgc_chk.sv
// Checker for the controller end of the refresh link.
// Assumes its inputs are the link signals and the controller clock.
`timescale 1ns/1ps
`include "rgc_defines.svh"
module rgc_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // Link signals
  input wire logic        ck,
  input wire logic        cs_n,
  input wire logic        act_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        bg1,
  input wire logic        bg0,
  input wire logic [1:0]  ba,
  input wire logic [13:0] addr
);
  logic        ck_q, ext, seen, prog, slot, is_ref, is_mrs;
  logic [2:0]  rate, mr;
  logic [1:0]  g;
  logic [10:0] gap, ival;
  logic [5:0]  need;

  default clocking dc @(posedge CLK); endclocking
  default disable iff (SRST);

  function automatic logic [1:0] fgran(input logic [2:0] r, input logic f);
    if (r == 3'h1 || (r == 3'h5 && f)) return 2'h1;
    if (r == 3'h2 || (r == 3'h6 && f)) return 2'h2;
    return 2'h0;
  endfunction

  assign slot   = ck_q & ~ck;
  assign is_ref = ~cs_n & act_n & ~ras_n & ~cas_n & we_n;
  assign is_mrs = ~cs_n & act_n & ~ras_n & ~cas_n & ~we_n;
  assign mr     = {bg1, ba};
  assign g      = fgran(rate, bg0);

  // ==========
  // Mode seen on the link and time since the last refresh
  always_ff @(posedge CLK) begin
    ck_q <= ck;
    if (SRST) begin
      rate <= 3'h0;
      ext  <= 1'b0;
      seen <= 1'b0;
      prog <= 1'b0;
      gap  <= 11'h7ff;
      ival <= 11'h0;
      need <= 6'h0;
    end else begin
      if (gap != 11'h7ff)
        gap <= gap + 11'h1;
      if (slot && is_mrs) begin
        seen <= 1'b0;
        if (mr == `RGC_MR_RATE)
          rate <= addr[8:6];
        if (mr == `RGC_MR_TCR) begin
          ext  <= addr[3] & addr[2];
          prog <= 1'b1;
        end
      end
      if (slot && is_ref) begin
        seen <= 1'b1;
        gap  <= 11'h1;
        ival <= (ext ? 11'(`RGC_TREFI_EXT_CYC) : 11'(`RGC_TREFI_BASE_CYC)) >> g;
        need <= (g == 2'h0) ? 6'(`RGC_TRFC1_CYC) :
                (g == 2'h1) ? 6'(`RGC_TRFC2_CYC) : 6'(`RGC_TRFC4_CYC);
      end
    end
  end

  // ==========
  // Assertions
  a_ck_high: assert property ($rose(ck) |=> ck ##1 !ck)
    else $error("link clock high phase wrong");
  a_ck_low: assert property ($fell(ck) |=> !ck ##1 ck)
    else $error("link clock low phase wrong");
  a_cmd_hold: assert property (!slot |-> $stable({cs_n, act_n, ras_n, cas_n, we_n, bg1, bg0, ba, addr}))
    else $error("command changed away from a clock fall");
  a_mrs_pair: assert property (slot && is_mrs && mr == 3'h3 |-> ##4 (slot && is_mrs && mr == 3'h4))
    else $error("rate write not followed by temperature write");
  a_tcr_only_1x: assert property (slot && is_mrs && mr == 3'h4 && addr[3] |-> rate == 3'h0)
    else $error("temperature refresh enabled outside fixed 1x");
  a_mode_first: assert property (slot && is_ref |-> prog)
    else $error("refresh before mode programming");
  a_rfc_wait: assert property (slot && !cs_n |-> gap >= 11'(need))
    else $error("command inside refresh cycle time");
  a_ref_late: assert property (slot && is_ref && seen |-> gap <= ival + 11'h8)
    else $error("refresh interval too long");
  a_ref_early: assert property (slot && is_ref && seen |-> gap >= ival - 11'h8)
    else $error("refresh interval too short");

  c_fine_ref: cover property (slot && is_ref && bg0);
  c_tcr_ext: cover property (slot && is_mrs && mr == 3'h4 && addr[3] && addr[2]);
  c_otf_mix: cover property (slot && is_ref && rate == 3'h6 && !bg0);
endmodule

// file: bench/testbench.sv
// Bench: controller and DRAM ends on one link, plus a second DRAM end fed
// by a bench driver that breaks the link rules on purpose.
// Assumes a 100 MHz CLK and the register map in rgc_defines.svh.
`timescale 1ns/1ps
`include "rgc_defines.svh"
module testbench;
  logic        CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e, hot, hot2;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, q, w;
  logic [2:0]  rm, rm2, c;
  logic [1:0]  gr, gr2;
  logic        ton, ton2, tex, tex2, ir, ir2, bz, bz2, et, et2, em, em2, f, tc, ex;
  int          n_fail = 0, checked = 0, n_int = 0, n_int2 = 0, s;
  logic [2:0]  ord [8] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h3, 3'h4, 3'h7};
  logic [13:0] mr4 [3] = '{14'h00c, 14'h00c, 14'h008};
  logic        fph = 1'b0;

  rgc_link_if lk ();
  rgc_link_if lk2 ();
  rgc_ctrl i_rgc_ctrl (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .link(lk));
  rgc_dram i_rgc_dram (.CLK(CLK), .SRST(SRST), .link(lk), .TEMP_HOT(hot), .RATE_MODE(rm),
    .TCR_ON(ton), .TCR_EXT(tex), .REF_GRAN(gr), .INT_REFRESH(ir), .RFC_BUSY(bz),
    .ERR_TIMING(et), .ERR_MODE(em));
  rgc_dram i_rgc_dram2 (.CLK(CLK), .SRST(SRST), .link(lk2), .TEMP_HOT(hot2), .RATE_MODE(rm2),
    .TCR_ON(ton2), .TCR_EXT(tex2), .REF_GRAN(gr2), .INT_REFRESH(ir2), .RFC_BUSY(bz2),
    .ERR_TIMING(et2), .ERR_MODE(em2));
  rgc_chk i_rgc_chk (.CLK(CLK), .SRST(SRST), .ck(lk.ck), .cs_n(lk.cs_n), .act_n(lk.act_n),
    .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .bg1(lk.bg1), .bg0(lk.bg0),
    .ba(lk.ba), .addr(lk.addr));

  always #5 CLK = ~CLK;

  always @(posedge CLK) begin
    if (ir === 1'b1)
      n_int++;
    if (ir2 === 1'b1)
      n_int2++;
  end

  // ==========
  // Tasks
  function automatic logic [1:0] egran(input logic [2:0] r, input logic fine);
    if (r == 3'h1 || (r == 3'h5 && fine)) return 2'h1;
    if (r == 3'h2 || (r == 3'h6 && fine)) return 2'h2;
    return 2'h0;
  endfunction

  task results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      $display("BAD apb_ready exp 1 got 0");
      results();
    end
  endtask

  task wref(input int n);
    int k;
    k = 0;
    s = n_int + n;
    while (n_int < s && k < 5000) begin
      @(posedge CLK);
      k++;
    end
    if (k >= 5000) begin
      n_fail++;
      $display("BAD wait_refresh exp %0d got %0d", s, n_int);
      results();
    end
  endtask

  // One command frame of 12 or 13 CLK in turn, 125 ns on average;
  // the clock then stands high and released lines flip
  task fcmd(input logic m, input logic [2:0] mr, input logic b, input logic [13:0] a,
            input int gapc);
    @(posedge CLK);
    {lk2.ck, lk2.cs_n, lk2.act_n, lk2.ras_n, lk2.cas_n, lk2.we_n} <= {5'h04, ~m};
    {lk2.bg1, lk2.ba, lk2.bg0, lk2.addr} <= {mr, b, a};
    repeat (6) @(posedge CLK);
    lk2.ck <= 1'b1;
    repeat (6 + fph) @(posedge CLK);
    fph = ~fph;
    lk2.cs_n <= 1'b1;
    {lk2.bg0, lk2.addr} <= ~{b, a};
    repeat (gapc) @(posedge CLK);
  endtask

  // ==========
  // Main sequence
  initial begin
    {CLK, SRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA, hot, hot2} = {2'h1, 45'h0};
    {lk2.ck, lk2.cs_n, lk2.act_n, lk2.ras_n, lk2.cas_n, lk2.we_n} = 6'h3f;
    {lk2.bg1, lk2.ba, lk2.bg0, lk2.addr} = 18'h0;
    void'($urandom(72160));
    repeat (6) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    chk("dram_rst", 32'h0, 32'({rm2, gr2, ton2, tex2, et2, em2, rm, gr, ton, tex, et, em}));
    apb(1'b0, `RGC_REG_CTRL, 32'h0);
    chk("ctrl_rst", 32'h0, q);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", 32'h1, 32'(e));
    chk("unmapped_data", 32'h0, q);
    $display("reset and register map test done");

    for (int i = 0; i < 10; i++) begin
      c = ord[i % 5];
      f = 1'($urandom_range(1, 0));
      tc = (c == 3'h0) & 1'($urandom_range(1, 0));
      ex = tc & 1'($urandom_range(1, 0));
      hot <= 1'($urandom_range(1, 0));
      w = {26'h0, 1'b1, ex, tc, c};
      apb(1'b1, `RGC_REG_OTF, {31'h0, f});
      apb(1'b1, `RGC_REG_CTRL, w);
      chk("ctrl_wr_err", 32'h0, 32'(e));
      wref(3);
      chk("rate_mode", 32'(c), 32'(rm));
      chk("ref_gran", 32'(egran(c, f)), 32'(gr));
      chk("tcr_bits", 32'({tc, ex}), 32'({ton, tex}));
      apb(1'b0, `RGC_REG_CTRL, 32'h0);
      chk("ctrl_rd", w, {26'h0, q[5:0]});
    end
    apb(1'b0, `RGC_REG_STATUS, 32'h0);
    chk("status_rsv", 32'h0, 32'({q[15:5], q[0]}));
    chk("status_refs", 32'h1, 32'(q[31:16] != 16'h0));
    chk("main_err", 32'h0, 32'({et, em}));
    $display("controller loop test done");

    for (int j = 0; j < 3; j++) begin
      hot2 <= (j == 1);
      fcmd(1'b1, 3'h4, 1'b0, mr4[j], 40);
      chk("tcr_bits2", 32'(mr4[j][3:2]), 32'({ton2, tex2}));
      s = n_int2;
      repeat (4) fcmd(1'b0, 3'h0, 1'b0, 14'h0, 40);
      chk("int_refresh", (j == 0) ? 32'h2 : 32'h4, 32'(n_int2 - s));
    end
    fcmd(1'b1, 3'h4, 1'b0, 14'h0, 40);
    for (int k = 0; k < 8; k++) begin
      c = ord[k];
      f = 1'($urandom_range(1, 0));
      fcmd(1'b1, 3'h3, 1'b0, {5'h0, c, 6'h0}, 40);
      fcmd(1'b0, 3'h0, f, 14'h0, 40);
      chk("rate2", 32'(c), 32'(rm2));
      chk("gran2", 32'(egran(c, f)), 32'(gr2));
      chk("err_mode", 32'(k > 4), 32'(em2));
    end
    chk("err_timing0", 32'h0, 32'(et2));
    fcmd(1'b0, 3'h0, 1'b0, 14'h0, 0);
    chk("rfc_busy", 32'h1, 32'(bz2));
    fcmd(1'b0, 3'h0, 1'b0, 14'h0, 40);
    chk("err_timing1", 32'h1, 32'(et2));
    $display("fault link test done");
    results();
  end
endmodule
